// ---- dcsw_bus_master.sv ----
`timescale 1ns/10ps
module dcsw_bus_master (
  input  wire logic  mclk_i,
  output logic       cw_strobe_o,
  output logic [15:0] command_word_o,
  output logic [15:0] speed_reference_word_o
);
  initial begin
    cw_strobe_o = 1'b0;
    command_word_o = 16'h0000;
    speed_reference_word_o = 16'h0000;
  end
  task automatic send(input logic [15:0] cw, input logic [15:0] sr);
    @(posedge mclk_i);
    cw_strobe_o <= 1'b1;
    command_word_o <= cw;
    speed_reference_word_o <= sr;
    @(posedge mclk_i);
    cw_strobe_o <= 1'b0;
    // Unqualified words show the inverse
    command_word_o <= ~cw;
    speed_reference_word_o <= ~sr;
  endtask : send
endmodule : dcsw_bus_master

// ---- dcsw_core.sv ----
`timescale 1ns/10ps
`include "dcsw_map.svh"
module dcsw_core
  import dcsw_pkg::*;
#(
  parameter int WORD_W = `DCSW_WORD_W
) (
  input  wire logic        mclk_i,
  input  wire logic        reset_i,
  input  wire logic        ce_i,
  input  wire logic        cw_strobe_i,
  input  wire logic [15:0] command_word_i,
  input  wire logic [15:0] speed_reference_word_i,
  input  wire logic [7:0]  relay1_func_i,
  input  wire logic [7:0]  relay2_func_i,
  input  wire logic [3:0]  active_setup_i,
  input  wire logic [1:0]  reverse_src_i,
  input  wire logic        di_reverse_i,
  input  wire logic        di_stop_n_i,
  input  wire logic        di_speed_up_i,
  input  wire logic        di_speed_down_i,
  input  wire logic        ctrl_ready_i,
  input  wire logic        drive_ready_i,
  input  wire logic        trip_i,
  input  wire logic        error_i,
  input  wire logic        triplock_i,
  input  wire logic        warning_i,
  input  wire logic        local_mode_i,
  input  wire logic        overtemp_i,
  input  wire logic        dc_link_bad_i,
  input  wire logic        current_limit_i,
  input  wire logic        thermal_over_i,
  input  wire logic        start_present_i,
  input  wire logic [15:0] output_freq_i,
  input  wire logic [15:0] freq_low_limit_i,
  input  wire logic [15:0] freq_high_limit_i,
  output logic [1:0]       preset_sel_o,
  output logic             dc_brake_o,
  output logic             coast_o,
  output logic             quick_stop_o,
  output logic             freeze_o,
  output logic             ramp_stop_o,
  output logic             start_o,
  output logic             trip_reset_o,
  output logic             jog_o,
  output logic             ramp2_o,
  output logic             relay1_o,
  output logic             relay2_o,
  output logic             setup2_o,
  output logic             reverse_o,
  output logic [15:0]      bus_reference_o,
  output logic [15:0]      drive_state_word_o,
  output logic [15:0]      scaled_output_frequency_o
);
  if (WORD_W != 16) begin : g_word_check
    $error("dcsw_core supports 16-bit words only");
  end

  ////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    logic [1:0]  sync1;
    logic [1:0]  sync2;
    logic [15:0] cw;
    logic [15:0] ref_w;
    logic [15:0] state_word;
    logic [15:0] actual_frequency_word;
    logic [15:0] hold_f;
    logic        rev;
    dcsw_mode_t  mode;
  } dcsw_state_t;
  dcsw_state_t st_q;
  dcsw_state_t st_d;

  // Reverse and stop pins pass two flops; only the second is read
  logic di_rev_s;
  logic di_stop_n_s;
  assign di_rev_s    = st_q.sync2[1];
  assign di_stop_n_s = st_q.sync2[0];

  logic take;
  logic rst_rise;
  assign take = cw_strobe_i & command_word_i[`DCSW_CW_VALID]; // R11

  dcsw_edge u_edge (
    .mclk_i  (mclk_i),
    .reset_i (reset_i),
    .ce_i    (ce_i),
    .take_i  (take),
    .level_i (command_word_i[`DCSW_CW_RESET]),
    .rise_o  (rst_rise)
  );

  logic in_limit;
  assign in_limit = ($signed(output_freq_i) > $signed(freq_low_limit_i)) &&
                    ($signed(output_freq_i) < $signed(freq_high_limit_i));

  always_comb begin
    st_d = st_q;
    st_d.sync1 = {di_reverse_i, di_stop_n_i};
    st_d.sync2 = st_q.sync1;
    if (take) begin
      st_d.cw = command_word_i; // R23
    end
    if (cw_strobe_i) begin
      st_d.ref_w = speed_reference_word_i; // R22
    end
    // Mode priority: coast, brake, freeze, then ramp stops
    if (!st_d.cw[`DCSW_CW_COAST_N] || !di_stop_n_s) begin
      st_d.mode = DCSW_COAST; // R3 R6
    end else if (!st_d.cw[`DCSW_CW_DCBRK_N]) begin
      st_d.mode = DCSW_DCBRK; // R2 R6
    end else if (!st_d.cw[`DCSW_CW_HOLD_N]) begin
      st_d.mode = DCSW_RUN; // R6
    end else if (!st_d.cw[`DCSW_CW_QSTOP_N]) begin
      st_d.mode = DCSW_QSTOP; // R4
    end else if (!st_d.cw[`DCSW_CW_START]) begin
      st_d.mode = DCSW_RSTOP; // R7
    end else begin
      st_d.mode = DCSW_RUN;
    end
    // Frozen frequency follows only speed up/down inputs
    if (st_q.cw[`DCSW_CW_HOLD_N] && !st_d.cw[`DCSW_CW_HOLD_N]) begin
      st_d.hold_f = output_freq_i; // R5
    end else if (!st_d.cw[`DCSW_CW_HOLD_N]) begin
      if (di_speed_up_i && !di_speed_down_i) begin
        st_d.hold_f = st_q.hold_f + 16'h0001; // R5
      end else if (di_speed_down_i && !di_speed_up_i) begin
        st_d.hold_f = st_q.hold_f - 16'h0001; // R5
      end
    end
    case (reverse_src_i)
      `DCSW_REV_BUS: st_d.rev = st_d.cw[`DCSW_CW_REVERSE]; // R14
      `DCSW_REV_AND: st_d.rev = st_d.cw[`DCSW_CW_REVERSE] & di_rev_s; // R14
      `DCSW_REV_OR:  st_d.rev = st_d.cw[`DCSW_CW_REVERSE] | di_rev_s; // R14
      default:       st_d.rev = di_rev_s; // R14
    endcase
    st_d.state_word = 16'h0000;
    st_d.state_word[`DCSW_SW_CTRL_RDY] = ctrl_ready_i & ~trip_i; // R15
    st_d.state_word[`DCSW_SW_DRV_RDY]  = drive_ready_i; // R15
    st_d.state_word[`DCSW_SW_ENABLE]   = st_q.mode != DCSW_COAST;
    st_d.state_word[`DCSW_SW_TRIP]     = trip_i; // R16
    st_d.state_word[`DCSW_SW_ERROR]    = error_i; // R16
    st_d.state_word[`DCSW_SW_TRIPLOCK] = triplock_i; // R16
    st_d.state_word[`DCSW_SW_WARNING]  = warning_i; // R17
    st_d.state_word[`DCSW_SW_AT_REF]   = output_freq_i == st_q.ref_w; // R18
    st_d.state_word[`DCSW_SW_BUS_CTRL] = ~local_mode_i; // R19
    st_d.state_word[`DCSW_SW_IN_LIMIT] = in_limit; // R20
    st_d.state_word[`DCSW_SW_RUNNING]  = start_present_i |
                                  (output_freq_i != 16'h0000); // R20
    st_d.state_word[`DCSW_SW_OVERTEMP] = overtemp_i; // R21
    st_d.state_word[`DCSW_SW_VOLTAGE]  = dc_link_bad_i; // R21
    st_d.state_word[`DCSW_SW_CURRENT]  = current_limit_i; // R21
    st_d.state_word[`DCSW_SW_THERMAL]  = thermal_over_i; // R21
    st_d.actual_frequency_word = output_freq_i; // R22
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      st_q      <= '0;
      st_q.cw   <= `DCSW_CW_RESET_VAL;
      st_q.mode <= DCSW_COAST;
      // Synchronisers start at pin idle levels
      st_q.sync1 <= 2'h1;
      st_q.sync2 <= 2'h1;
    end else if (ce_i) begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs
  assign preset_sel_o = st_q.cw[`DCSW_CW_REF_LSB +: 2]; // R1
  assign coast_o      = st_q.mode == DCSW_COAST; // R3
  assign dc_brake_o   = st_q.mode == DCSW_DCBRK; // R2
  assign quick_stop_o = st_q.mode == DCSW_QSTOP; // R4
  assign ramp_stop_o  = st_q.mode == DCSW_RSTOP; // R7
  assign freeze_o     = ~st_q.cw[`DCSW_CW_HOLD_N] &
                        (st_q.mode == DCSW_RUN); // R5
  assign start_o      = st_q.mode == DCSW_RUN;
  assign trip_reset_o = rst_rise; // R8
  assign jog_o        = st_q.cw[`DCSW_CW_JOG]; // R9
  assign ramp2_o      = st_q.cw[`DCSW_CW_RAMP2]; // R10
  assign relay1_o     = st_q.cw[`DCSW_CW_RELAY1] &
                        (relay1_func_i == `DCSW_RELAY1_FUNC); // R12
  assign relay2_o     = st_q.cw[`DCSW_CW_RELAY2] &
                        (relay2_func_i == `DCSW_RELAY2_FUNC); // R12
  assign setup2_o     = st_q.cw[`DCSW_CW_SETUP] &
                        (active_setup_i == `DCSW_MULTI_SETUP); // R13
  assign reverse_o    = st_q.rev;
  assign bus_reference_o           = st_q.ref_w;
  assign drive_state_word_o        = st_q.state_word;
  assign scaled_output_frequency_o = st_q.actual_frequency_word;
endmodule : dcsw_core

// ---- dcsw_core_properties.sv ----
`timescale 1ns/10ps
module dcsw_core_properties (
  input  wire logic        mclk_i,
  input  wire logic        reset_i,
  input  wire logic        ce_i,
  input  wire logic        cw_strobe_i,
  input  wire logic [15:0] command_word_i,
  input  wire logic [15:0] speed_reference_word_i,
  input  wire logic        di_stop_n_i,
  input  wire logic        trip_i,
  input  wire logic        error_i,
  input  wire logic        triplock_i,
  input  wire logic        warning_i,
  input  wire logic [1:0]  preset_sel_o,
  input  wire logic        dc_brake_o,
  input  wire logic        coast_o,
  input  wire logic        trip_reset_o,
  input  wire logic [15:0] bus_reference_o,
  input  wire logic [15:0] drive_state_word_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  logic       acc;
  logic       rst_q;
  logic [3:0] stp_q;
  assign acc = ce_i && cw_strobe_i && command_word_i[10];
  always_ff @(posedge mclk_i) begin
    stp_q <= {stp_q[2:0], di_stop_n_i};
    if (reset_i) rst_q <= 1'b0;
    else if (acc) rst_q <= command_word_i[7];
  end
  sequence rise_s;
    acc && command_word_i[7] && !rst_q;
  endsequence
  preset_sel_a: assert property (acc |=>
    preset_sel_o == $past(command_word_i[1:0])) else $error("preset bad");
  word_ignore_a: assert property (ce_i && cw_strobe_i &&
    !command_word_i[10] |=> $stable(preset_sel_o)) else $error("not ignored");
  coast_cmd_a: assert property (acc && !command_word_i[3]
    |=> coast_o) else $error("no coast");
  brake_cmd_a: assert property (acc && command_word_i[3:2] == 2'b10
    && &stp_q |=> dc_brake_o && !coast_o) else $error("no brake");
  trip_rise_a: assert property (rise_s |=> trip_reset_o)
    else $error("no trip reset");
  trip_level_a: assert property (acc && command_word_i[7] && rst_q
    |=> !trip_reset_o) else $error("level reset");
  fault_bits_a: assert property (ce_i |=> drive_state_word_o[7:3] ==
    {$past(warning_i), $past(triplock_i), 1'b0, $past(error_i),
     $past(trip_i)}) else $error("fault bits bad");
  bus_ref_a: assert property (ce_i && cw_strobe_i |=>
    bus_reference_o == $past(speed_reference_word_i)) else $error("ref bad");
endmodule : dcsw_core_properties
bind dcsw_core dcsw_core_properties chk (.mclk_i, .reset_i, .ce_i,
  .cw_strobe_i, .command_word_i, .speed_reference_word_i, .di_stop_n_i,
  .trip_i, .error_i, .triplock_i, .warning_i, .preset_sel_o, .dc_brake_o,
  .coast_o, .trip_reset_o, .bus_reference_o, .drive_state_word_o);

// ---- dcsw_edge.sv ----
`timescale 1ns/10ps
module dcsw_edge (
  input  wire logic mclk_i,
  input  wire logic reset_i,
  input  wire logic ce_i,
  input  wire logic take_i,
  input  wire logic level_i,
  output logic      rise_o
);
  typedef struct packed {
    logic prev;
    logic rise;
  } dcsw_edge_t;
  dcsw_edge_t st_q;
  dcsw_edge_t st_d;
  always_comb begin
    st_d = st_q;
    st_d.rise = 1'b0;
    if (take_i) begin
      st_d.rise = level_i & ~st_q.prev; // R8
      st_d.prev = level_i;
    end
  end
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      st_q <= '0;
    end else if (ce_i) begin
      st_q <= st_d;
    end
  end
  assign rise_o = st_q.rise;
endmodule : dcsw_edge

// ---- dcsw_map.svh ----
// Operation
// R1: Control bits 1:0 pick one of four preset references.
// R2: Bit 2 low applies DC braking and stop; high allows ramping.
// R3: Bit 3 low shuts output stage off to coast; high allows start.
// R4: Bit 4 low ramps to standstill on the quick-stop ramp.
// R5: Bit 5 low freezes output frequency; only speed-up/down inputs change it.
// R6: While frozen, stop only on coast, DC brake or inverse stop inputs.
// R7: Bit 6 low ramps down on selected ramp; high permits start.
// R8: A trip clears only on a rising edge of bit 7.
// R9: Bit 8 high sets output frequency from jog speed.
// R10: Bit 9 selects ramp pair one or two.
// R11: Bit 10 low makes the whole control word ignored.
// R12: Bits 11 and 12 drive relays when relay function is 36 or 37.
// R13: Bit 13 selects set-up 1 or 2 only in multi set-up mode 9.
// R14: Bit 15 reverses only when reversing source is bus, AND or OR.
// R15: Status bit 0 is controls ready, bit 1 drive ready.
// R16: Status bits 3, 4, 6 report trip, error, triplock; bit 5 unused.
// R17: Status bit 7 reflects any present warning.
// R18: Status bit 8 is set when speed equals reference.
// R19: Status bit 9 set when the fieldbus may control the drive.
// R20: Bit 10 frequency within limits; bit 11 start present or running.
// R21: Bits 12-15: overtemp auto start, DC link, current limit, thermal.
// R22: Speed reference and actual frequency are signed, 16384 is 100%.
// R23: Hold last accepted control word; refresh status every cycle.
`ifndef DCSW_MAP_SVH
`define DCSW_MAP_SVH
`define DCSW_WORD_W        16
`define DCSW_CW_REF_LSB    0
`define DCSW_CW_DCBRK_N    2
`define DCSW_CW_COAST_N    3
`define DCSW_CW_QSTOP_N    4
`define DCSW_CW_HOLD_N     5
`define DCSW_CW_START      6
`define DCSW_CW_RESET      7
`define DCSW_CW_JOG        8
`define DCSW_CW_RAMP2      9
`define DCSW_CW_VALID      10
`define DCSW_CW_RELAY1     11
`define DCSW_CW_RELAY2     12
`define DCSW_CW_SETUP      13
`define DCSW_CW_REVERSE    15
`define DCSW_SW_CTRL_RDY   0
`define DCSW_SW_DRV_RDY    1
`define DCSW_SW_ENABLE     2
`define DCSW_SW_TRIP       3
`define DCSW_SW_ERROR      4
`define DCSW_SW_TRIPLOCK   6
`define DCSW_SW_WARNING    7
`define DCSW_SW_AT_REF     8
`define DCSW_SW_BUS_CTRL   9
`define DCSW_SW_IN_LIMIT   10
`define DCSW_SW_RUNNING    11
`define DCSW_SW_OVERTEMP   12
`define DCSW_SW_VOLTAGE    13
`define DCSW_SW_CURRENT    14
`define DCSW_SW_THERMAL    15
`define DCSW_CW_RESET_VAL  16'h0000
`define DCSW_FULL_SCALE    16'sh4000
`define DCSW_RELAY1_FUNC   8'h24
`define DCSW_RELAY2_FUNC   8'h25
`define DCSW_MULTI_SETUP   4'h9
`define DCSW_REV_INPUT     2'h0
`define DCSW_REV_BUS       2'h1
`define DCSW_REV_AND       2'h2
`define DCSW_REV_OR        2'h3
`endif

// ---- dcsw_pkg.sv ----
package dcsw_pkg;
  typedef enum logic [4:0] {
    DCSW_RUN   = 5'h01,
    DCSW_COAST = 5'h02,
    DCSW_DCBRK = 5'h04,
    DCSW_QSTOP = 5'h08,
    DCSW_RSTOP = 5'h10
  } dcsw_mode_t;
endpackage : dcsw_pkg

// ---- drive_control_status_word_tb.sv ----
`timescale 1ns/10ps
module drive_control_status_word_tb;
  logic        mclk_i;
  logic        reset_i = 1'b1;
  logic        stb;
  logic [15:0] cw, sr, bref, st;
  logic [7:0]  r1f = 8'h00, r2f = 8'h00;
  logic [3:0]  setup = 4'h0;
  logic [1:0]  rsrc = 2'h0, psel;
  logic [11:0] fl = 12'h000;
  logic [15:0] freq = 16'h0000, lo = 16'h0000, hi = 16'h0000;
  logic [4:0]  mode;
  logic [6:0]  misc;
  logic        rev;
  logic        stop_n = 1'b1;
  logic        di_rev = 1'b0;
  logic [15:0] mavw;
  int          err_count = 0;
  int          total_checks = 0;
  int          cycles = 0;
  dcsw_bus_master bfm (.mclk_i, .cw_strobe_o(stb), .command_word_o(cw),
    .speed_reference_word_o(sr));
  dcsw_core dut (.mclk_i, .reset_i, .ce_i(1'b1), .cw_strobe_i(stb),
    .command_word_i(cw), .speed_reference_word_i(sr), .relay1_func_i(r1f),
    .relay2_func_i(r2f), .active_setup_i(setup), .reverse_src_i(rsrc),
    .di_reverse_i(di_rev), .di_stop_n_i(stop_n), .di_speed_up_i(1'b0),
    .di_speed_down_i(1'b0), .ctrl_ready_i(fl[0]), .drive_ready_i(fl[1]),
    .trip_i(fl[2]), .error_i(fl[3]), .triplock_i(fl[4]),
    .warning_i(fl[5]), .local_mode_i(fl[6]), .overtemp_i(fl[7]),
    .dc_link_bad_i(fl[8]), .current_limit_i(fl[9]),
    .thermal_over_i(fl[10]), .start_present_i(fl[11]),
    .output_freq_i(freq), .freq_low_limit_i(lo), .freq_high_limit_i(hi),
    .preset_sel_o(psel), .coast_o(mode[4]), .dc_brake_o(mode[3]),
    .quick_stop_o(mode[2]), .freeze_o(mode[1]), .ramp_stop_o(mode[0]),
    .start_o(misc[6]), .trip_reset_o(misc[5]), .jog_o(misc[4]),
    .ramp2_o(misc[3]), .relay1_o(misc[2]), .relay2_o(misc[1]),
    .setup2_o(misc[0]), .reverse_o(rev), .bus_reference_o(bref),
    .drive_state_word_o(st), .scaled_output_frequency_o(mavw));
  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      err_count++;
    end
  endtask : chk
  task automatic tx(input logic [15:0] w, input logic [15:0] r);
    bfm.send(w, r);
    #1;
  endtask : tx
  task automatic t_presets;
    for (int k = 0; k < 4; k++) begin
      tx(16'h047C | 16'(k) | (16'(k) << 8), 16'hC000 + 16'(k));
      chk("preset", 16'(k), {14'h0, psel});
      chk("ramp_jog", 16'(k), {14'h0, misc[3], misc[4]});
      chk("start", 16'h0001, {15'h0, misc[6]});
      chk("bus_ref", 16'hC000 + 16'(k), bref);
    end
  endtask : t_presets
  task automatic t_ignore;
    tx(16'h047D, 16'h1234);
    tx(16'h0082, 16'h4000);
    chk("ignored", 16'h0001, {14'h0, psel});
    chk("no_reset", 16'h0000, {15'h0, misc[5]});
    chk("ref_any", 16'h4000, bref);
  endtask : t_ignore
  task automatic t_modes;
    logic [15:0] wt [7] = '{16'h0474, 16'h0478, 16'h046C, 16'h045C,
                            16'h043C, 16'h0458, 16'h044C};
    logic [4:0]  mt [7] = '{5'h10, 5'h08, 5'h04, 5'h02, 5'h01, 5'h08, 5'h02};
    for (int k = 0; k < 7; k++) begin
      tx(wt[k], 16'h0000);
      chk("mode", 16'(mt[k]), 16'(mode));
    end
    // Inverse stop pin must end the frozen run
    @(posedge mclk_i);
    stop_n <= 1'b0;
    repeat (3) @(posedge mclk_i);
    #1;
    chk("pin_stop", 16'h0010, 16'(mode));
    @(posedge mclk_i);
    stop_n <= 1'b1;
    repeat (3) @(posedge mclk_i);
    #1;
    chk("pin_release", 16'h0002, 16'(mode));
  endtask : t_modes
  task automatic t_reset;
    tx(16'h04FC, 16'h0000);
    chk("trip_reset", 16'h0001, {15'h0, misc[5]});
    @(posedge mclk_i);
    #1;
    chk("pulse_end", 16'h0000, {15'h0, misc[5]});
    tx(16'h04FC, 16'h0000);
    chk("level", 16'h0000, {15'h0, misc[5]});
  endtask : t_reset
  task automatic t_config;
    for (int k = 0; k < 4; k++) begin
      @(posedge mclk_i);
      r1f <= (k == 2) ? 8'h25 : 8'h24;
      r2f <= (k == 1) ? 8'h25 : 8'h24;
      setup <= (k == 3) ? 4'h9 : 4'h1;
      rsrc <= 2'(k);
      di_rev <= (k == 2);
      // Let the reverse pin through its synchroniser
      repeat (2) @(posedge mclk_i);
      tx(16'hBC7C, 16'h0000);
      chk("cfg", {12'h0, k != 2, k == 1, k == 3, k != 0},
          {12'h0, misc[2:0], rev});
    end
  endtask : t_config
  task automatic t_status(input logic [11:0] f, input logic [15:0] q);
    logic [15:0] e;
    @(posedge mclk_i);
    fl <= f;
    freq <= q;
    lo <= 16'h1000;
    hi <= 16'h3000;
    repeat (2) @(posedge mclk_i);
    #1;
    // Last reference sent was zero; drive is running
    e = {f[10:7], f[11] | (q != 16'h0000), ($signed(q) > 16'sh1000) &&
         ($signed(q) < 16'sh3000), !f[6], q == 16'h0000, f[5:4], 1'b0,
         f[3:2], 1'b1, f[1], f[0] & !f[2]};
    chk("state", e, st);
    chk("mav", q, mavw);
  endtask : t_status
  task automatic test_done;
    if (err_count == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : test_done
  initial begin
    mclk_i = 1'b0;
    forever #2 mclk_i = ~mclk_i;
  end
  always @(posedge mclk_i) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      err_count++;
      test_done();
    end
  end
  initial begin
    repeat (20) @(posedge mclk_i);
    reset_i <= 1'b0;
    #1;
    chk("reset_mode", 16'h0010, 16'(mode));
    t_presets();
    t_ignore();
    t_modes();
    t_reset();
    t_config();
    t_status(12'hAAA, 16'h2000);
    t_status(12'h555, 16'hF000);
    t_status(12'h000, 16'h3000);
    t_status(12'h000, 16'h0000);
    test_done();
  end
endmodule : drive_control_status_word_tb
